// ---- design/aspfi_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Operation
// - port is link slave and never generates link clocks
// - both channels sampled together, 24-bit words arrive alternately
// - transmit interrupt on every channel-select rising edge
// - one transmit and two receive interrupts per channel-select period
// - receive interrupt after last word bit; word then readable
// - transmit event marks next word left; single modes drop the channel not chosen
// - dual mode processing ends 500 ns before next receive interrupt
// - dual mode budget per word is about 9 us
// - timing flag high while channel processing runs
// - single channel in 9 us runs as dual with one channel chosen
// - extended mode gives left the right slot, budget 18 us
// - channel-select rise clears right-next flag
// - extended left work spans right interrupt, then writes transmit word
// - bit clock, channel select and serial out also on output pins
// - 32-bit slots, 24 data bits, 8 zero bits
// - data starts one bit clock after channel-select transition
// - serial input captured on bit-clock rising edges
// - output shifted on the same bit clock as input
module aspfi_top #(
    parameter int PROC_LAT = 64
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic bit_clk,
    input wire logic ch_sel,
    input wire logic sdata_in,
    output logic sdata_out,
    output logic bit_clk_out,
    output logic ch_sel_out,
    output logic sdata_mon_out,
    input wire aspfi_pkg::aspfi_mode_e mode,
    output logic frame_transmit_interrupt,
    output logic word_receive_interrupt,
    output logic timing_flag_output,
    output logic budget_overrun,
    output logic [aspfi_pkg::DATA_BITS-1:0] rx_data,
    output logic rx_data_right,
    output logic rx_data_valid,
    input wire logic [aspfi_pkg::DATA_BITS-1:0] proc_result,
    input wire logic proc_done
);
    import aspfi_pkg::*;

    if (PROC_LAT < 1 || PROC_LAT > BUDGET_CYC) begin : g_bad_lat
        $error("PROC_LAT out of range");
    end

    aspfi_xfer_if x ();
    logic sdata_link;

    // clocks are only taken in, nothing here drives them
    aspfi_link u_link (
        .bit_clk(bit_clk),
        .ch_sel(ch_sel),
        .sdata_in(sdata_in),
        .sdata_out(sdata_link),
        .x(x)
    );

    // ------------------------------------------------------------
    // output pin copies: select and data on the link clock, bit clock mirror on clk_sys
    // ------------------------------------------------------------
    always_ff @(posedge bit_clk) begin
        ch_sel_out <= ch_sel;
    end

    // data changes on the falling edge so the converter samples it on the rising one
    always_ff @(negedge bit_clk) begin
        sdata_out <= sdata_link;
        sdata_mon_out <= sdata_link;
    end

    // bit clock mirror, sampled in system domain (3.072 MHz vs 100 MHz)
    logic [1:0] bclk_sync_q;
    always_ff @(posedge clk_sys) begin
        bclk_sync_q <= {bclk_sync_q[0], bit_clk};
        bit_clk_out <= bclk_sync_q[1];
    end

    // ------------------------------------------------------------
    // toggle crossings into clk_sys
    // ------------------------------------------------------------
    logic [2:0] rx_sync_q;
    logic [2:0] fs_sync_q;
    logic rx_evt;
    logic fs_evt;

    // no reset: the chains keep following the toggles, so leaving reset fakes no event
    always_ff @(posedge clk_sys) begin
        rx_sync_q <= {rx_sync_q[1:0], x.rx_tgl};
        fs_sync_q <= {fs_sync_q[1:0], x.fs_tgl};
    end

    assign rx_evt = rx_sync_q[2] ^ rx_sync_q[1];
    assign fs_evt = fs_sync_q[2] ^ fs_sync_q[1];

    // mode is a pin: two flops before anything decodes it
    aspfi_mode_e mode_s_q;
    aspfi_mode_e mode_q;
    always_ff @(posedge clk_sys) begin
        mode_s_q <= mode;
        mode_q <= mode_s_q;
    end

    // ------------------------------------------------------------
    // interrupts and channel tagging
    // ------------------------------------------------------------
    logic right_next_q;
    logic dropped;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            frame_transmit_interrupt <= 1'b0;
            word_receive_interrupt <= 1'b0;
        end else begin
            frame_transmit_interrupt <= fs_evt;
            word_receive_interrupt <= rx_evt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            right_next_q <= 1'b0;
        end else if (fs_evt) begin
            right_next_q <= 1'b0;
        end else if (rx_evt) begin
            right_next_q <= 1'b1;
        end
    end

    // word stable in link domain for a whole slot, safe to take on the event
    always_comb begin
        case (mode_q)
            ASPFI_MODE_SINGLE_L: dropped = right_next_q;
            ASPFI_MODE_SINGLE_R: dropped = ~right_next_q;
            ASPFI_MODE_EXTENDED: dropped = right_next_q;
            default: dropped = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rx_data <= WORD_ZERO;
            rx_data_right <= 1'b0;
            rx_data_valid <= 1'b0;
        end else begin
            rx_data_valid <= rx_evt & ~dropped;
            if (rx_evt) begin
                rx_data <= x.rx_word;
                rx_data_right <= right_next_q;
            end
        end
    end

    // ------------------------------------------------------------
    // processing window, budget and timing flag
    // ------------------------------------------------------------
    aspfi_chan_e chan_q;
    logic [CNT_W-1:0] run_q;
    logic [CNT_W-1:0] limit;
    logic [DATA_BITS-1:0] tx_left_q;
    logic [DATA_BITS-1:0] tx_right_q;

    // extended: left work keeps running across the right-word event
    assign limit = (mode_q == ASPFI_MODE_EXTENDED) ? CNT_W'(EXT_BUDGET_CYC - GUARD_CYC)
        : CNT_W'(BUDGET_CYC - GUARD_CYC);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            chan_q <= ASPFI_IDLE;
            run_q <= '0;
            timing_flag_output <= 1'b0;
            budget_overrun <= 1'b0;
        end else begin
            budget_overrun <= 1'b0;
            case (chan_q)
                ASPFI_IDLE: begin
                    if (rx_evt && !dropped) begin
                        chan_q <= right_next_q ? ASPFI_RIGHT : ASPFI_LEFT;
                        run_q <= '0;
                        timing_flag_output <= 1'b1;
                    end
                end
                default: begin
                    run_q <= run_q + 1'b1;
                    if (proc_done || run_q == limit) begin
                        chan_q <= ASPFI_IDLE;
                        timing_flag_output <= 1'b0;
                        budget_overrun <= ~proc_done;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tx_left_q <= WORD_ZERO;
            tx_right_q <= WORD_ZERO;
        end else if (chan_q != ASPFI_IDLE && proc_done) begin
            if (chan_q == ASPFI_LEFT) begin
                tx_left_q <= proc_result;
            end else begin
                tx_right_q <= proc_result;
            end
        end else if (fs_evt && mode_q == ASPFI_MODE_EXTENDED) begin
            // copied just after the rise sampling point and a slot before the fall one, so no torn word
            tx_right_q <= tx_left_q;
        end
    end

    // sampled by the link only at channel-select edges, left at the rise and right at the fall; words are then long settled
    assign x.tx_left = tx_left_q;
    assign x.tx_right = tx_right_q;
endmodule // aspfi_top
`default_nettype wire

// ---- design/aspfi_pkg.sv ----
package aspfi_pkg;
    // ------------------------------------------------------------
    // link format
    // ------------------------------------------------------------
    localparam int SLOT_BITS = 32;
    localparam int DATA_BITS = 24;
    localparam int PAD_BITS = 8;
    localparam int FRAME_BITS = 64;
    localparam int DATA_DELAY = 1;
    localparam logic [5:0] SLOT_CNT_ZERO = 6'h00;
    localparam logic [DATA_BITS-1:0] WORD_ZERO = 24'h000000;

    // ------------------------------------------------------------
    // timing budgets, system clock 100 MHz
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int GUARD_NS = 500;
    localparam int BUDGET_NS = 9000;
    localparam int EXT_BUDGET_NS = 18000;
    localparam int GUARD_CYC = (GUARD_NS * CLK_MHZ + 999) / 1000;
    localparam int BUDGET_CYC = (BUDGET_NS * CLK_MHZ) / 1000;
    localparam int EXT_BUDGET_CYC = (EXT_BUDGET_NS * CLK_MHZ) / 1000;
    localparam int CNT_W = 12;

    typedef enum logic [1:0] {
        ASPFI_IDLE = 2'b00,
        ASPFI_LEFT = 2'b01,
        ASPFI_RIGHT = 2'b10
    } aspfi_chan_e;

    typedef enum logic [1:0] {
        ASPFI_MODE_DUAL = 2'b00,
        ASPFI_MODE_SINGLE_L = 2'b01,
        ASPFI_MODE_SINGLE_R = 2'b10,
        ASPFI_MODE_EXTENDED = 2'b11
    } aspfi_mode_e;
endpackage

// ---- design/aspfi_xfer_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// word and event crossing between the link and system domains
interface aspfi_xfer_if;
    import aspfi_pkg::*;
    logic rx_tgl;
    logic rx_right;
    logic [DATA_BITS-1:0] rx_word;
    logic fs_tgl;
    logic tx_ack_tgl;
    logic [DATA_BITS-1:0] tx_left;
    logic [DATA_BITS-1:0] tx_right;
    modport link (output rx_tgl, output rx_right, output rx_word, output fs_tgl,
        output tx_ack_tgl, input tx_left, input tx_right);
    modport core (input rx_tgl, input rx_right, input rx_word, input fs_tgl,
        input tx_ack_tgl, output tx_left, output tx_right);
endinterface
`default_nettype wire

// ---- design/aspfi_link.sv ----
`timescale 1ns/1ps
`default_nettype none
// link-clock side: slave shifter, runs only on the converter's bit clock
module aspfi_link (
    input wire logic bit_clk,
    input wire logic ch_sel,
    input wire logic sdata_in,
    output logic sdata_out,
    aspfi_xfer_if.link x
);
    import aspfi_pkg::*;

    // no reset reaches this domain: the toggles start known so the crossings see no false event
    logic ch_sel_q = 1'b0;
    logic [5:0] cnt_q;
    logic [SLOT_BITS-1:0] sh_in_q;
    logic [SLOT_BITS-1:0] sh_out_q;
    logic rx_tgl_q = 1'b0;
    logic rx_right_q;
    logic [DATA_BITS-1:0] rx_word_q;
    logic fs_tgl_q = 1'b0;
    logic ack_q = 1'b0;
    logic rise;
    logic fall;

    assign rise = ch_sel & ~ch_sel_q;
    assign fall = ~ch_sel & ch_sel_q;

    // ------------------------------------------------------------
    // bit counter aligned to channel-select edges
    // ------------------------------------------------------------
    always_ff @(posedge bit_clk) begin
        ch_sel_q <= ch_sel;
        if (rise || fall) begin
            cnt_q <= SLOT_CNT_ZERO;
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // receive: rising-edge capture, word done after last data bit
    // ------------------------------------------------------------
    always_ff @(posedge bit_clk) begin
        sh_in_q <= {sh_in_q[SLOT_BITS-2:0], sdata_in};
        if (cnt_q == 6'(DATA_BITS - 1)) begin
            // msb-first 24 bits, pad bits ignored
            rx_word_q <= {sh_in_q[DATA_BITS-2:0], sdata_in};
            rx_right_q <= ~ch_sel_q;
            rx_tgl_q <= ~rx_tgl_q;
        end
        if (rise) begin
            fs_tgl_q <= ~fs_tgl_q;
        end
    end

    // ------------------------------------------------------------
    // transmit: same bit clock, left word in the slot that follows the rise
    // ------------------------------------------------------------
    always_ff @(posedge bit_clk) begin
        if (rise) begin
            sh_out_q <= {x.tx_left, {PAD_BITS{1'b0}}};
            ack_q <= ~ack_q;
        end else if (fall) begin
            sh_out_q <= {x.tx_right, {PAD_BITS{1'b0}}};
        end else begin
            sh_out_q <= {sh_out_q[SLOT_BITS-2:0], 1'b0};
        end
    end

    // the pin flop in the top takes this on the falling edge: msb one bit after the edge
    assign sdata_out = sh_out_q[SLOT_BITS-1];

    assign x.rx_tgl = rx_tgl_q;
    assign x.rx_right = rx_right_q;
    assign x.rx_word = rx_word_q;
    assign x.fs_tgl = fs_tgl_q;
    assign x.tx_ack_tgl = ack_q;
endmodule // aspfi_link
`default_nettype wire

// ---- testbench/aspfi_top_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module aspfi_top_chk #(
    parameter int PROC_LAT = 64
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic ch_sel,
    input wire logic frame_transmit_interrupt,
    input wire logic word_receive_interrupt,
    input wire logic timing_flag_output,
    input wire logic [aspfi_pkg::DATA_BITS-1:0] rx_data,
    input wire logic rx_data_valid,
    input wire logic proc_done
);
    import aspfi_pkg::*;
    // ----
    // words seen since the last frame event
    // ----
    logic [1:0] nw_q;
    logic seen_q;
    always_ff @(posedge clk_sys) begin
        if (srst || frame_transmit_interrupt) begin
            nw_q <= 2'h0;
        end else if (word_receive_interrupt && nw_q != 2'h3) begin
            nw_q <= nw_q + 2'h1;
        end
    end
    // the first frame after reset may be partial, so it is not judged
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            seen_q <= 1'b0;
        end else if (frame_transmit_interrupt) begin
            seen_q <= 1'b1;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    AST_FTI_ONCE: assert property (frame_transmit_interrupt |=> !frame_transmit_interrupt [*8])
        else $error("frame interrupt not a single pulse");
    AST_FTI_CAUSE: assert property ($rose(ch_sel) |-> ##[1:8] frame_transmit_interrupt)
        else $error("no frame interrupt after channel select rise");
    AST_THREE_INTS: assert property (frame_transmit_interrupt && seen_q |-> nw_q == 2'h2)
        else $error("frame did not hold two word interrupts");
    AST_WRI_SPACE: assert property (word_receive_interrupt |=> !word_receive_interrupt [*8])
        else $error("word interrupts too close");
    AST_VALID_INT: assert property (rx_data_valid |-> word_receive_interrupt)
        else $error("word accepted without interrupt");
    AST_RX_HOLD: assert property (!word_receive_interrupt |-> $stable(rx_data))
        else $error("received word changed between interrupts");
    AST_FLAG_RISE: assert property ($rose(timing_flag_output) |-> rx_data_valid)
        else $error("timing flag rose without an accepted word");
    AST_FLAG_END: assert property (timing_flag_output && proc_done |=> !timing_flag_output)
        else $error("timing flag stayed high after result");
    cover property (rx_data_valid);
    cover property ($fell(timing_flag_output));
    cover property (frame_transmit_interrupt && seen_q);
endmodule // aspfi_top_chk
bind aspfi_top aspfi_top_chk #(.PROC_LAT(PROC_LAT)) u_chk (.clk_sys, .srst, .ch_sel, .frame_transmit_interrupt,
    .word_receive_interrupt, .timing_flag_output, .rx_data, .rx_data_valid, .proc_done);
`default_nettype wire

// ---- testbench/aspfi_conv_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module aspfi_conv_model (
    output logic bit_clk,
    output logic ch_sel,
    output logic sdata,
    input wire logic sdata_out,
    input wire logic [23:0] word_l,
    input wire logic [23:0] word_r,
    output logic [31:0] cap_l,
    output logic [31:0] cap_r
);
    // ----
    // leading unit and link master: bit clock runs free, channel select is bit clock / 64
    // ----
    logic [5:0] cnt = 6'h3f;
    logic [5:0] nxt;
    logic [23:0] w;
    logic [31:0] sh = 32'h0;
    initial begin
        bit_clk = 1'b0;
        ch_sel = 1'b0;
        sdata = 1'b0;
        cap_l = 32'h0;
        cap_r = 32'h0;
        #3.7;
        forever #6 bit_clk = ~bit_clk;
    end
    // data changes on the falling edge so the port can take it on the rising one;
    // channel select high carries the left word, so the frame event comes before it
    always @(negedge bit_clk) begin
        nxt = cnt + 6'h01;
        w = nxt[5] ? word_l : word_r;
        cnt <= nxt;
        ch_sel <= nxt[5];
        sdata <= (nxt[4:0] != 5'h00 && nxt[4:0] < 5'h19) ? w[5'h18 - nxt[4:0]] : 1'b0;
    end
    // a full slot is kept each time, so a late or padded bit shows up in the compare
    always @(posedge bit_clk) begin
        sh = {sh[30:0], sdata_out};
        if (cnt[4:0] == 5'h00) begin
            if (cnt[5]) begin
                cap_r <= sh;
            end else begin
                cap_l <= sh;
            end
        end
    end
endmodule // aspfi_conv_model
`default_nettype wire

// ---- testbench/aspfi_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module aspfi_bench;
    import aspfi_pkg::*;
    // ----
    // converter model, device and result feeder
    // ----
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic bit_clk, ch_sel, sdata_in, sdata_out;
    logic frame_transmit_interrupt, word_receive_interrupt, timing_flag_output, budget_overrun;
    logic rx_data_right, rx_data_valid;
    logic bit_clk_out, ch_sel_out, sdata_mon_out, bclk_prev;
    int nbc = 0;
    logic proc_done = 1'b0;
    logic [DATA_BITS-1:0] rx_data;
    logic [DATA_BITS-1:0] proc_result = WORD_ZERO;
    logic [31:0] cap_l, cap_r;
    aspfi_mode_e mode = ASPFI_MODE_DUAL;
    int n_mismatch = 0;
    int tests_run = 0;
    int nf = 0;
    int nl = 0;
    int nr = 0;
    int pend = 0;
    localparam logic [23:0] WL = 24'h9c3a15;
    localparam logic [23:0] WR = 24'h46e2b7;
    always #5 clk_sys = ~clk_sys;
    aspfi_conv_model CONV (.bit_clk, .ch_sel, .sdata(sdata_in), .sdata_out, .word_l(WL), .word_r(WR), .cap_l, .cap_r);
    aspfi_top #(.PROC_LAT(64)) DUT (.clk_sys, .srst, .bit_clk, .ch_sel, .sdata_in, .sdata_out, .bit_clk_out,
        .ch_sel_out, .sdata_mon_out, .mode, .frame_transmit_interrupt, .word_receive_interrupt,
        .timing_flag_output, .budget_overrun, .rx_data, .rx_data_right, .rx_data_valid, .proc_result, .proc_done);
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wait_frames(input int n);
        int t;
        t = nf + n;
        for (int i = 0; i < 200 * n && nf < t; i++) @(posedge clk_sys);
        chk("frames", nf >= t, 1);
    endtask
    // pin copies: channel select is taken on the rising edge, the monitor follows the data pin
    always @(posedge bit_clk) begin
        #1;
        if (nf > 1) begin
            chk("ch_sel_out", ch_sel_out, ch_sel);
            chk("sdata_mon_out", sdata_mon_out, sdata_out);
        end
    end
    // results come back a few cycles after each accepted word once two frames have passed, well inside the budget
    always @(posedge clk_sys) begin
        #1;
        proc_done = (pend == 1);
        if (pend != 0) pend--;
        if (frame_transmit_interrupt === 1'b1) nf++;
        if (bit_clk_out !== bclk_prev) nbc++;
        bclk_prev = bit_clk_out;
        if (nf > 1 && budget_overrun !== 1'b0) chk("overrun", budget_overrun, 0);
        if (nf > 1 && rx_data_valid === 1'b1) begin
            if (rx_data_right) nr++;
            else nl++;
            chk("rx_data", rx_data, rx_data_right ? WR : WL);
            pend = 6;
        end
    end
    task automatic run_mode(input aspfi_mode_e m, input logic [23:0] r, input int el, input int er);
        @(posedge clk_sys);
        #1;
        mode = m;
        proc_result = r;
        wait_frames(3);
        nl = 0;
        nr = 0;
        nbc = 0;
        wait_frames(4);
        chk("left words", nl, el);
        chk("right words", nr, er);
        chk("bit clock mirror", nbc > 20, 1);
        if (el != 0) chk("left out", cap_l, {r, 8'h00});
        if (er != 0 || m == ASPFI_MODE_EXTENDED) chk("right out", cap_r, {r, 8'h00});
        $display("test mode %0d done", m);
    endtask
    task automatic mid_reset;
        @(posedge clk_sys);
        #1;
        srst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk("reset outputs", {frame_transmit_interrupt, word_receive_interrupt, rx_data_valid, timing_flag_output}, 0);
        srst = 1'b0;
        $display("test reset done");
    endtask
    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        run_mode(ASPFI_MODE_DUAL, 24'h3c5a81, 4, 4);
        run_mode(ASPFI_MODE_SINGLE_L, 24'h7e0193, 4, 0);
        run_mode(ASPFI_MODE_SINGLE_R, 24'hc4b20f, 0, 4);
        run_mode(ASPFI_MODE_EXTENDED, 24'h15ad6e, 4, 0);
        mid_reset;
        run_mode(ASPFI_MODE_DUAL, 24'ha9f034, 4, 4);
        tally_and_finish;
    end
    initial begin
        #100000;
        n_mismatch++;
        tally_and_finish;
    end
endmodule // aspfi_bench
`default_nettype wire
